// ---- bench/core_model.sv ----
// Behavioural program sequencer and return stack facing the interrupt logic
module core_model
  import irq_pkg::*;
#(
  parameter int STACK_DEPTH = 1
)
(
  input  wire logic i_clock,           // System clock
  input  wire logic i_sys_rst,         // Reset, high
  input  wire logic i_push_pc,         // Entry push
  input  wire logic i_pop_pc,          // Return pop
  input  wire logic i_return_from_irq_req,        // Bench asks for interrupt return
  input  wire logic i_ret_req,         // Bench asks for plain return
  output logic      o_stack_full,      // No free entry
  output logic      o_return_from_irq, // Interrupt return executed
  output logic      o_return_plain     // Plain return executed
);
  logic [7:0] pc;
  logic [7:0] stack [STACK_DEPTH];
  int         depth;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      pc <= 8'h00;
      depth <= 0;
      o_return_from_irq <= 1'b0;
      o_return_plain <= 1'b0;
    end else begin
      pc <= pc + 8'h01;
      if (i_push_pc && depth < STACK_DEPTH) begin
        stack[depth] <= pc;
        depth <= depth + 1;
      end else if (i_pop_pc && depth > 0) begin
        pc <= stack[depth-1];
        depth <= depth - 1;
      end
      o_return_from_irq <= i_return_from_irq_req;
      o_return_plain <= i_ret_req;
    end
  end
  assign o_stack_full = (depth == STACK_DEPTH);
endmodule

// ---- bench/irq_port_assertions.sv ----
// Port-level concurrent checks for the grouped interrupt logic
module irq_port_checker
  import irq_pkg::*;
#(
  parameter int TIMER_COUNT = 2
)
(
  input wire logic    i_clock, // System clock
  input wire logic    i_sys_rst, // Reset, high
  input wire logic    i_wb_cyc, // Bus cycle
  input wire logic    i_wb_stb, // Bus strobe
  input wire logic    o_wb_ack, // Bus acknowledge
  input wire logic    i_stack_full, // Stack full
  input wire logic    i_return_from_irq, // Interrupt return
  input wire logic    i_return_plain, // Plain return
  input wire vector_t o_vector, // Vector entry
  input wire logic    o_push_pc, // Push pulse
  input wire logic    o_pop_pc, // Pop pulse
  input wire logic    o_time_base_overflow // Period pulse
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  // Cycles since the last overflow
  logic [15:0] gap;
  logic        gap_valid;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      gap <= 16'h0000;
      gap_valid <= 1'b0;
    end else if (o_time_base_overflow) begin
      gap <= 16'h0000;
      gap_valid <= 1'b1;
    end else if (gap != 16'hffff) begin
      gap <= gap + 16'h0001;
    end
  end

  push_with_entry_a: assert property (o_push_pc == o_vector.strobe)
    else $error("push without entry");
  full_blocks_entry_a: assert property (i_stack_full |=> !o_vector.strobe)
    else $error("entry while full");
  return_pops_a: assert property ((i_return_from_irq || i_return_plain) |=> o_pop_pc)
    else $error("return without pop");
  pop_has_cause_a: assert property (o_pop_pc |-> $past(i_return_from_irq || i_return_plain))
    else $error("pop without return");
  one_entry_a: assert property (o_vector.strobe |=> !o_vector.strobe || $past(i_return_from_irq, 2) || $past(i_wb_stb, 2))
    else $error("second entry");
  group_range_a: assert property (o_vector.strobe |-> o_vector.group != 2'h3)
    else $error("bad group");
  tb_min_period_a: assert property ((o_time_base_overflow && gap_valid) |-> gap >= 16'd255)
    else $error("period too short");
  ack_follows_a: assert property ((i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
    else $error("no ack");
  ack_single_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack too long");
endmodule

bind grouped_interrupt_wakeup_logic irq_port_checker #(.TIMER_COUNT(TIMER_COUNT)) u_chk (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack),
  .i_stack_full(i_stack_full), .i_return_from_irq(i_return_from_irq), .i_return_plain(i_return_plain),
  .o_vector(o_vector), .o_push_pc(o_push_pc), .o_pop_pc(o_pop_pc), .o_time_base_overflow(o_time_base_overflow));

// ---- bench/tb_top.sv ----
// Self-checking bench for the grouped interrupt and wake-up logic
module tb_top
  import irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clock, rst, cyc, stb, we, ack, radio, eedone, lowsup, sub_clk;
  logic              stack_full, ret_irq, ret_plain, return_from_irq_req, ret_req, push_pc, pop_pc, wakeup, ovf;
  logic [ADDR_W-1:0] adr;
  logic [31:0]       wdat, odat, rdat;
  logic [1:0]        tma, tmp;
  vector_t           vec;
  int                n_fail, check_count, wake_cnt, vec_cnt, ovf_cnt, ovf_gap, cyc_n, ovf_last;

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  grouped_interrupt_wakeup_logic #(.TIMER_COUNT(2)) DUT (.i_clock(clock), .i_sys_rst(rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(odat),
    .o_wb_ack(ack), .i_radio_data(radio), .i_eeprom_done(eedone), .i_low_supply(lowsup),
    .i_timer_match_a(tma), .i_timer_match_p(tmp), .i_sub_clock(sub_clk), .i_stack_full(stack_full),
    .i_return_from_irq(ret_irq), .i_return_plain(ret_plain), .o_vector(vec), .o_push_pc(push_pc),
    .o_pop_pc(pop_pc), .o_wakeup(wakeup), .o_time_base_overflow(ovf));
  core_model #(.STACK_DEPTH(1)) u_core (.i_clock(clock), .i_sys_rst(rst), .i_push_pc(push_pc),
    .i_pop_pc(pop_pc), .i_return_from_irq_req(return_from_irq_req), .i_ret_req(ret_req), .o_stack_full(stack_full),
    .o_return_from_irq(ret_irq), .o_return_plain(ret_plain));

  always @(posedge clock) begin
    cyc_n <= cyc_n + 1;
    if (wakeup === 1'b1) wake_cnt <= wake_cnt + 1;
    if (vec.strobe === 1'b1) vec_cnt <= vec_cnt + 1;
    if (ovf === 1'b1) begin
      ovf_gap <= cyc_n - ovf_last;
      ovf_last <= cyc_n;
      ovf_cnt <= ovf_cnt + 1;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic hang(input string what);
    n_fail++;
    $display("mismatch %s expected event seen none", what);
    finish_test();
  endtask
  // Request held until ack is sampled high
  task automatic wb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = odat;
    cyc <= 1'b0; stb <= 1'b0;
    if (n >= 20) hang("bus ack");
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
    wb(1'b0, a, 32'h0);
    check(what, rdat, exp);
  endtask
  task automatic expect_vec(input logic [1:0] g);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (vec.strobe !== 1'b1 && n < 40);
    if (n >= 40) hang("vector strobe");
    check("vector group", {30'h0, vec.group}, {30'h0, g});
    check("push with entry", {31'h0, push_pc}, 32'h1);
  endtask
  task automatic do_ret(input logic irq);
    @(posedge clock);
    return_from_irq_req <= irq; ret_req <= !irq;
    @(posedge clock);
    return_from_irq_req <= 1'b0; ret_req <= 1'b0;
  endtask

  task automatic t_reset();
    for (int i = 0; i < 10; i++) rd(ADDR_W'(4 * i), (i == 6) ? GROUP_MAP_RST : 32'h0, "reset value");
    wb(1'b1, OFF_TB_CONTROL, 32'hff);
    rd(OFF_TB_CONTROL, 32'h87, "time base control");
    wb(1'b1, OFF_STATUS, 32'h1f);
    rd(OFF_STATUS, 32'h0, "status read only");
    wb(1'b1, 6'h3c, 32'hff);
    rd(6'h3c, 32'h0, "unmapped");
    wb(1'b1, OFF_SRC_ENABLE, 32'h7);
    rd(OFF_SRC_ENABLE, 32'h7, "source enables");
    wb(1'b1, OFF_TB_CONTROL, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_eeprom();
    wb(1'b1, OFF_SRC_ENABLE, 32'h2);
    wb(1'b1, OFF_CONTROL, 32'h3);
    @(posedge clock);
    eedone <= 1'b1;
    @(posedge clock);
    eedone <= 1'b0;
    expect_vec(2'h0);
    rd(OFF_SRC_FLAGS, 32'h2, "source flag kept");
    rd(OFF_GROUP_FLAGS, 32'h0, "group flag cleared");
    rd(OFF_STATUS, 32'h10, "entry status");
    wb(1'b1, OFF_SRC_FLAGS, 32'h0);
    do_ret(1'b1);
    repeat (3) @(posedge clock);
    rd(OFF_STATUS, 32'h08, "interrupt return");
    wb(1'b1, OFF_CONTROL, 32'h0);
    $display("test eeprom entry done");
  endtask
  task automatic t_wake();
    int base;
    wb(1'b1, OFF_SRC_ENABLE, 32'h0);
    base = wake_cnt;
    @(posedge clock);
    radio <= 1'b1;
    repeat (6) @(posedge clock);
    check("wake on radio edge", {31'h0, wake_cnt > base}, 32'h1);
    rd(OFF_SRC_FLAGS, 32'h4, "radio rising");
    wb(1'b1, OFF_SRC_FLAGS, 32'h0);
    radio <= 1'b0;
    repeat (6) @(posedge clock);
    rd(OFF_SRC_FLAGS, 32'h4, "radio falling");
    tma <= 2'b10;
    tmp <= 2'b01;
    @(posedge clock);
    tma <= 2'b00;
    tmp <= 2'b00;
    rd(OFF_TM_FLAGS, 32'h6, "timer flags");
    rd(OFF_GROUP_FLAGS, 32'h6, "group flags");
    wb(1'b1, OFF_TM_FLAGS, 32'h0);
    wb(1'b1, OFF_GROUP_FLAGS, 32'h0);
    wb(1'b1, OFF_SRC_FLAGS, 32'h1);
    repeat (4) @(posedge clock);
    base = wake_cnt;
    lowsup <= 1'b1;
    repeat (8) @(posedge clock);
    check("preset blocks wake", wake_cnt - base, 32'h0);
    wb(1'b1, OFF_SRC_FLAGS, 32'h0);
    lowsup <= 1'b0;
    repeat (4) @(posedge clock);
    lowsup <= 1'b1;
    repeat (6) @(posedge clock);
    rd(OFF_SRC_FLAGS, 32'h1, "low supply flag");
    rd(OFF_SRC_FLAGS, 32'h1, "flag persists");
    lowsup <= 1'b0;
    wb(1'b1, OFF_SRC_FLAGS, 32'h0);
    wb(1'b1, OFF_GROUP_FLAGS, 32'h0);
    $display("test wake done");
  endtask
  task automatic t_priority();
    int base;
    wb(1'b1, OFF_SRC_FLAGS, 32'h5);
    wb(1'b1, OFF_CONTROL, 32'h7);
    base = vec_cnt;
    repeat (10) @(posedge clock);
    check("sources off", vec_cnt - base, 32'h0);
    wb(1'b1, OFF_SRC_ENABLE, 32'h5);
    expect_vec(2'h0);
    wb(1'b1, OFF_CONTROL, 32'h7);
    base = vec_cnt;
    repeat (10) @(posedge clock);
    check("stack full", vec_cnt - base, 32'h0);
    do_ret(1'b0);
    expect_vec(2'h1);
    do_ret(1'b0);
    repeat (3) @(posedge clock);
    rd(OFF_STATUS, 32'h0, "plain return");
    rd(OFF_SRC_FLAGS, 32'h5, "source flags kept");
    wb(1'b1, OFF_SRC_FLAGS, 32'h0);
    wb(1'b1, OFF_SRC_ENABLE, 32'h0);
    $display("test priority done");
  endtask
  task automatic t_time_base();
    logic [1:0] psel [3] = '{2'h0, 2'h0, 2'h1};
    logic [2:0] code [3] = '{3'h0, 3'h1, 3'h0};
    int         gaps [3] = '{256, 512, 1024};
    int         base, n;
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, OFF_TB_CONTROL, 32'h0);
      wb(1'b1, OFF_PRESCALE, {30'h0, psel[i]});
      wb(1'b1, OFF_TB_CONTROL, {24'h0, 5'h10, code[i]});
      base = ovf_cnt;
      n = 0;
      while (ovf_cnt < base + 2 && n < 3000) begin
        @(posedge clock);
        n++;
      end
      if (n >= 3000) hang("time base overflow");
      check("time base period", 32'(ovf_gap), 32'(gaps[i]));
    end
    wb(1'b1, OFF_TB_CONTROL, 32'h0);
    wb(1'b1, OFF_PRESCALE, 32'h0);
    base = ovf_cnt;
    repeat (400) @(posedge clock);
    check("disabled time base", ovf_cnt - base, 32'h0);
    $display("test time base done");
  endtask

  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; wdat = 32'h0; radio = 1'b0; eedone = 1'b0;
    lowsup = 1'b0; sub_clk = 1'b0; tma = 2'b00; tmp = 2'b00; return_from_irq_req = 1'b0; ret_req = 1'b0;
    n_fail = 0; check_count = 0; wake_cnt = 0; vec_cnt = 0; ovf_cnt = 0; ovf_gap = 0; cyc_n = 0; ovf_last = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_eeprom();
    t_wake();
    t_priority();
    t_time_base();
    finish_test();
  end
endmodule

// ---- hdl/grouped_interrupt_wakeup_logic.sv ----
// Grouped interrupt request, vectoring, wake-up and second time base logic
// Operation
// - Second time base runs and overflows only while its enable bit is one.
// - Period code selects two to the power eight plus code prescaled ticks.
// - Radio data rising or falling edge sets the radio edge flag.
// - Vector only with global, source and group enables set and stack not full.
// - Three grouped channels combine timer, EEPROM, low supply and radio flags.
// - A group flag sets when any source flag assigned to it becomes set.
// - Service clears global enable and group flag, never the source flag.
// - EEPROM flag sets when an EEPROM write cycle finishes.
// - Low supply flag sets when the detector reports supply below threshold.
// - Each timer has comparator A and P flags with matching enables.
// - Any flag rising wakes the device regardless of enables.
// - Flags stay set until serviced or cleared; enables only stop service.
// - Entry pushes only the program counter.
// - Interrupt return sets global enable; plain return leaves it clear.
// - Radio, EEPROM, low supply enables sit at bits 2, 1, 0.
// - Prescaler source: system clock, system clock over four, or subsidiary clock.
// - No request is acknowledged while the stack is full.
//
// The register offsets and the Wishbone register port were left to the implementer.
module grouped_interrupt_wakeup_logic
  import irq_pkg::*;
#(
  parameter int TIMER_COUNT = 2
)
(
  input  wire logic                   i_clock,          // System clock, 100 MHz
  input  wire logic                   i_sys_rst,        // Synchronous reset, high
  input  wire logic                   i_wb_cyc,         // Wishbone cycle
  input  wire logic                   i_wb_stb,         // Wishbone strobe
  input  wire logic                   i_wb_we,          // Wishbone write
  input  wire logic [ADDR_W-1:0]      i_wb_adr,         // Wishbone byte address
  input  wire logic [31:0]            i_wb_dat,         // Wishbone write data
  input  wire logic [3:0]             i_wb_sel,         // Wishbone byte enables
  output logic [31:0]                 o_wb_dat,         // Wishbone read data
  output logic                        o_wb_ack,         // Wishbone acknowledge
  input  wire logic                   i_radio_data,     // Demodulated radio data, async
  input  wire logic                   i_eeprom_done,    // Write cycle finished pulse
  input  wire logic                   i_low_supply,     // Detector output, async
  input  wire logic [TIMER_COUNT-1:0] i_timer_match_a,  // Comparator A match pulses
  input  wire logic [TIMER_COUNT-1:0] i_timer_match_p,  // Comparator P match pulses
  input  wire logic                   i_sub_clock,      // Subsidiary clock, async
  input  wire logic                   i_stack_full,     // Return stack has no free entry
  input  wire logic                   i_return_from_irq, // Interrupt return executed
  input  wire logic                   i_return_plain,   // Plain return executed
  output vector_t                     o_vector,         // Vector entry strobe and group
  output logic                        o_push_pc,        // Push program counter pulse
  output logic                        o_pop_pc,         // Pop program counter pulse
  output logic                        o_wakeup,         // Wake from sleep or idle pulse
  output logic                        o_time_base_overflow // Second time base period pulse
);

  localparam int NSRC  = NUM_BASIC + 2 * TIMER_COUNT;
  localparam int MAP_W = GROUP_IDX_W * NSRC;

  // Control and status state
  logic                   global_irq_enable;
  logic [NUM_GROUPS-1:0]  group_enable;
  logic [NUM_GROUPS-1:0]  group_request_flag;
  logic [NUM_GROUPS-1:0]  group_flag_prev;
  logic [NUM_BASIC-1:0]   basic_enable;
  logic [NUM_BASIC-1:0]   basic_flag;
  logic [2*TIMER_COUNT-1:0] tm_enable;
  logic [2*TIMER_COUNT-1:0] tm_flag;
  logic [MAP_W-1:0]       group_map;
  logic [7:0]             time_base_two_control;
  logic [1:0]             prescaler_source_select;
  logic [NSRC-1:0]        src_flag_prev;

  // Synchronisers and edge state
  logic [SYNC_STAGES-1:0] radio_sync;
  logic [SYNC_STAGES-1:0] low_sync;
  logic [SYNC_STAGES-1:0] sub_sync;
  logic                   radio_prev;
  logic                   low_prev;
  logic                   sub_prev;
  logic [1:0]             div4_count;
  logic                   prescaled_clock;

  // Combinational terms
  logic                   bus_req;
  logic                   wr;
  logic [31:0]            wr_word;
  logic [NUM_BASIC-1:0]   basic_set;
  logic [2*TIMER_COUNT-1:0] tm_set;
  logic [NSRC-1:0]        src_flag;
  logic [NSRC-1:0]        src_enable;
  logic [NSRC-1:0]        src_rise;
  logic [NUM_GROUPS-1:0]  group_set;
  logic [NUM_GROUPS-1:0]  group_ready;
  logic [NUM_GROUPS-1:0]  service_clear;
  logic                   take;
  logic [GROUP_IDX_W-1:0] pick;
  logic [31:0]            rd_word;

  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Bus slave: answers every address one cycle after the request
  assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr      = bus_req && i_wb_we;

  always_comb begin
    wr_word = 32'h0;
    unique case (i_wb_adr)
      OFF_CONTROL:     wr_word = lanes({28'h0, group_enable, global_irq_enable}, i_wb_dat, i_wb_sel);
      OFF_GROUP_FLAGS: wr_word = lanes({29'h0, group_request_flag}, i_wb_dat, i_wb_sel);
      OFF_SRC_ENABLE:  wr_word = lanes({29'h0, basic_enable}, i_wb_dat, i_wb_sel);
      OFF_SRC_FLAGS:   wr_word = lanes({29'h0, basic_flag}, i_wb_dat, i_wb_sel);
      OFF_TM_ENABLE:   wr_word = lanes(32'(tm_enable), i_wb_dat, i_wb_sel);
      OFF_TM_FLAGS:    wr_word = lanes(32'(tm_flag), i_wb_dat, i_wb_sel);
      OFF_GROUP_MAP:   wr_word = lanes(32'(group_map), i_wb_dat, i_wb_sel);
      OFF_TB_CONTROL:  wr_word = lanes({24'h0, time_base_two_control}, i_wb_dat, i_wb_sel);
      OFF_PRESCALE:    wr_word = lanes({30'h0, prescaler_source_select}, i_wb_dat, i_wb_sel);
      default:         wr_word = 32'h0;
    endcase
  end

  always_comb begin
    unique case (i_wb_adr)
      OFF_CONTROL:     rd_word = {28'h0, group_enable, global_irq_enable};
      OFF_GROUP_FLAGS: rd_word = {29'h0, group_request_flag};
      OFF_SRC_ENABLE:  rd_word = {29'h0, basic_enable};
      OFF_SRC_FLAGS:   rd_word = {29'h0, basic_flag};
      OFF_TM_ENABLE:   rd_word = 32'(tm_enable);
      OFF_TM_FLAGS:    rd_word = 32'(tm_flag);
      OFF_GROUP_MAP:   rd_word = 32'(group_map);
      // Bits 6 to 3 are unimplemented and read as zero
      OFF_TB_CONTROL:  rd_word = {24'h0, time_base_two_control[TB_ENABLE_BIT], 4'h0,
                                  time_base_two_control[TB_PERIOD_LSB +: TB_PERIOD_W]};
      OFF_PRESCALE:    rd_word = {30'h0, prescaler_source_select};
      OFF_STATUS:      rd_word = {27'h0, i_stack_full, global_irq_enable, group_ready};
      default:         rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end else begin
      o_wb_ack <= bus_req;
      o_wb_dat <= (bus_req && !i_wb_we) ? rd_word : 32'h0;
    end
  end

  // Two flip-flops before any logic reads an asynchronous input
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      radio_sync <= '0;
      low_sync   <= '0;
      sub_sync   <= '0;
      radio_prev <= 1'b0;
      low_prev   <= 1'b0;
      sub_prev   <= 1'b0;
    end else begin
      radio_sync <= {radio_sync[0], i_radio_data};
      low_sync   <= {low_sync[0], i_low_supply};
      sub_sync   <= {sub_sync[0], i_sub_clock};
      radio_prev <= radio_sync[SYNC_STAGES-1];
      low_prev   <= low_sync[SYNC_STAGES-1];
      sub_prev   <= sub_sync[SYNC_STAGES-1];
    end
  end

  assign basic_set[2] = radio_sync[SYNC_STAGES-1] ^ radio_prev;
  assign basic_set[1] = i_eeprom_done;
  // Entry into low supply sets the flag, so it can be cleared while low
  assign basic_set[0] = low_sync[SYNC_STAGES-1] && !low_prev;

  for (genvar k = 0; k < TIMER_COUNT; k++) begin : g_tm
    assign tm_set[2*k]   = i_timer_match_a[k];
    assign tm_set[2*k+1] = i_timer_match_p[k];
  end

  // Prescaled clock as a one-cycle tick in the system domain
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      div4_count      <= 2'h0;
      prescaled_clock <= 1'b0;
    end else begin
      div4_count <= 2'(div4_count + 1'b1);
      unique case (psc_src_t'(prescaler_source_select))
        PSC_SYS:      prescaled_clock <= 1'b1;
        PSC_SYS_DIV4: prescaled_clock <= (div4_count == DIV4_LAST);
        PSC_SUB,
        PSC_SUB_ALT:  prescaled_clock <= sub_sync[SYNC_STAGES-1] && !sub_prev;
      endcase
    end
  end

  time_base_two u_time_base_two (
    .i_clock         (i_clock),
    .i_sys_rst       (i_sys_rst),
    .i_enable        (time_base_two_control[TB_ENABLE_BIT]),
    .i_period_select (time_base_two_control[TB_PERIOD_LSB +: TB_PERIOD_W]),
    .i_tick          (prescaled_clock),
    .o_overflow      (o_time_base_overflow)
  );

  // Grouping of source flags
  assign src_flag   = {tm_flag, basic_flag};
  assign src_enable = {tm_enable, basic_enable};
  assign src_rise   = src_flag & ~src_flag_prev;

  always_comb begin
    group_set   = '0;
    group_ready = '0;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      for (int s = 0; s < NSRC; s++) begin
        if (group_map[GROUP_IDX_W*s +: GROUP_IDX_W] == GROUP_IDX_W'(g)) begin
          group_set[g]   = group_set[g] | src_rise[s];
          group_ready[g] = group_ready[g] | (src_flag[s] & src_enable[s]);
        end
      end
      group_ready[g] = group_ready[g] & group_enable[g] & group_request_flag[g];
    end
  end

  // Lowest ready group wins; entry blocked while the stack is full
  always_comb begin
    pick = '0;
    for (int g = NUM_GROUPS - 1; g >= 0; g--) begin
      if (group_ready[g]) begin
        pick = GROUP_IDX_W'(g);
      end
    end
  end

  assign take = global_irq_enable && (|group_ready) && !i_stack_full;

  always_comb begin
    service_clear = '0;
    if (take) begin
      service_clear[pick] = 1'b1;
    end
  end

  // Global enable: entry clears it, interrupt return sets it
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      global_irq_enable <= CONTROL_RST[CTRL_GIE_BIT];
      group_enable      <= CONTROL_RST[CTRL_GEN_LSB +: NUM_GROUPS];
    end else begin
      if (wr && i_wb_adr == OFF_CONTROL) begin
        global_irq_enable <= wr_word[CTRL_GIE_BIT];
        group_enable      <= wr_word[CTRL_GEN_LSB +: NUM_GROUPS];
      end
      if (i_return_from_irq) begin
        global_irq_enable <= 1'b1;
      end
      if (take) begin
        global_irq_enable <= 1'b0;
      end
    end
  end

  // Flags: hardware set wins over a clear in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      group_request_flag <= '0;
      basic_flag         <= '0;
      tm_flag            <= '0;
    end else begin
      group_request_flag <= (((wr && i_wb_adr == OFF_GROUP_FLAGS) ? wr_word[NUM_GROUPS-1:0]
                             : group_request_flag) & ~service_clear) | group_set;
      // Software alone clears source flags
      basic_flag <= ((wr && i_wb_adr == OFF_SRC_FLAGS) ? wr_word[NUM_BASIC-1:0]
                     : basic_flag) | basic_set;
      tm_flag    <= ((wr && i_wb_adr == OFF_TM_FLAGS) ? wr_word[2*TIMER_COUNT-1:0]
                     : tm_flag) | tm_set;
    end
  end

  // Remaining software settings
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      basic_enable            <= '0;
      tm_enable               <= '0;
      group_map               <= GROUP_MAP_RST[MAP_W-1:0];
      time_base_two_control   <= TB_CONTROL_RST;
      prescaler_source_select <= PRESCALE_RST;
    end else if (wr) begin
      if (i_wb_adr == OFF_SRC_ENABLE) begin
        basic_enable <= {wr_word[RADIO_EN_BIT], wr_word[EEPROM_EN_BIT], wr_word[LOW_EN_BIT]};
      end
      if (i_wb_adr == OFF_TM_ENABLE) begin
        tm_enable <= wr_word[2*TIMER_COUNT-1:0];
      end
      if (i_wb_adr == OFF_GROUP_MAP) begin
        group_map <= wr_word[MAP_W-1:0];
      end
      if (i_wb_adr == OFF_TB_CONTROL) begin
        time_base_two_control <= wr_word[7:0];
      end
      if (i_wb_adr == OFF_PRESCALE) begin
        prescaler_source_select <= wr_word[1:0];
      end
    end
  end

  // Vector entry, stack strobes and wake-up
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_vector        <= '0;
      o_push_pc       <= 1'b0;
      o_pop_pc        <= 1'b0;
      o_wakeup        <= 1'b0;
      src_flag_prev   <= '0;
      group_flag_prev <= '0;
    end else begin
      o_vector.strobe <= take;
      o_vector.group  <= pick;
      // Software saves anything beyond the program counter
      o_push_pc       <= take;
      o_pop_pc        <= i_return_from_irq || i_return_plain;
      src_flag_prev   <= src_flag;
      group_flag_prev <= group_request_flag;
      o_wakeup        <= (|src_rise) || (|(group_request_flag & ~group_flag_prev));
    end
  end

endmodule

// ---- hdl/irq_pkg.sv ----
// Shared constants, register map and types of the grouped interrupt and wake-up logic
package irq_pkg;

  localparam int ADDR_W = 6;

  // Register byte offsets, one aligned 32-bit word each
  localparam logic [ADDR_W-1:0] OFF_CONTROL     = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_GROUP_FLAGS = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_SRC_ENABLE  = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_SRC_FLAGS   = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_TM_ENABLE   = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_TM_FLAGS    = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_GROUP_MAP   = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_TB_CONTROL  = 6'h1c;
  localparam logic [ADDR_W-1:0] OFF_PRESCALE    = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_STATUS      = 6'h24;

  // Field positions
  localparam int CTRL_GIE_BIT   = 0;
  localparam int CTRL_GEN_LSB   = 1;
  localparam int LOW_EN_BIT     = 0;
  localparam int EEPROM_EN_BIT  = 1;
  localparam int RADIO_EN_BIT   = 2;
  localparam int TB_ENABLE_BIT  = 7;
  localparam int TB_PERIOD_LSB  = 0;
  localparam int TB_PERIOD_W    = 3;
  localparam int TB_COUNT_W     = 15;
  localparam int TB_BASE_EXP    = 8;
  localparam int STAT_FULL_BIT  = 4;
  localparam int STAT_GIE_BIT   = 3;

  // Grouping
  localparam int NUM_GROUPS    = 3;
  localparam int NUM_BASIC     = 3;
  localparam int GROUP_IDX_W   = 2;
  localparam int SYNC_STAGES   = 2;

  // Values after reset
  localparam logic [7:0]  CONTROL_RST    = 8'h00;
  localparam logic [7:0]  TB_CONTROL_RST = 8'h00;
  localparam logic [1:0]  PRESCALE_RST   = 2'h0;
  localparam logic [31:0] GROUP_MAP_RST  = 32'h00002a90;
  localparam logic [1:0]  DIV4_LAST      = 2'h3;

  typedef enum logic [1:0] {
    PSC_SYS      = 2'b00,
    PSC_SYS_DIV4 = 2'b01,
    PSC_SUB      = 2'b10,
    PSC_SUB_ALT  = 2'b11
  } psc_src_t;

  // One vector entry presented to the program sequencer
  typedef struct packed {
    logic                   strobe;
    logic [GROUP_IDX_W-1:0] group;
  } vector_t;

endpackage

// ---- hdl/time_base_two.sv ----
// Second time base: counts prescaled ticks and pulses once per selected period
module time_base_two
  import irq_pkg::*;
(
  input  wire logic                   i_clock,         // System clock
  input  wire logic                   i_sys_rst,       // Synchronous reset, high
  input  wire logic                   i_enable,        // Run while high
  input  wire logic [TB_PERIOD_W-1:0] i_period_select, // Period code
  input  wire logic                   i_tick,          // Prescaled clock tick
  output logic                        o_overflow       // One-cycle period pulse
);

  logic [TB_COUNT_W-1:0] count;
  logic [TB_COUNT_W-1:0] mask;

  // Low 8+code bits all ones marks the last tick of a period
  assign mask = TB_COUNT_W'((32'h1 << (TB_BASE_EXP + int'(i_period_select))) - 32'h1);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      count      <= '0;
      o_overflow <= 1'b0;
    end else if (!i_enable) begin
      count      <= '0;
      o_overflow <= 1'b0;
    end else begin
      o_overflow <= i_tick && ((count & mask) == mask);
      if (i_tick) begin
        count <= TB_COUNT_W'(count + 1'b1);
      end
    end
  end

endmodule
